// file: rtl/lb_cal_pkg.sv
/*
 * constants for the loopback and delay calibration control block.
 * assumes a 32-bit axi4-lite register bus, byte addressed.
 */
package lb_cal_pkg;
    localparam logic [7:0]  OFS_LOOPBACK  = 8'h44;
    localparam logic [7:0]  OFS_STATUS    = 8'h48;
    localparam logic [7:0]  OFS_RTD_CTRL  = 8'h4C;
    localparam int          FWD_POS       = 0;
    localparam int          FWD_W         = 2;
    localparam int          REV_POS       = 4;
    localparam int          REV_W         = 4;
    localparam int          OFF_POS       = 0;
    localparam int          OFF_W         = 5;
    localparam logic [1:0]  FWD_SERIAL    = 2'h1;
    localparam int          ST_SER        = 0;
    localparam int          ST_PAR        = 1;
    localparam int          ST_REV        = 2;
    localparam int          ST_RTD        = 3;
    localparam int          ST_STCAL      = 4;
    localparam int          ST_RECONF     = 5;
    localparam int          ST_DBG        = 6;
    localparam int          ST_OFF_POS    = 8;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [31:0] RST_LOOPBACK  = 32'h00000000;
    localparam int          RTD_DEPTH_MIN = 2;
    localparam int          RTD_DEPTH_MAX = 4;
    localparam int          RTD_DEPTH_DEF = 2;
endpackage

// file: rtl/rtd_if.sv
/*
 * link between the control block and the round-trip delay buffer.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface rtd_if #(parameter int W = 32);
    logic signed [lb_cal_pkg::OFF_W-1:0] target;
    logic signed [lb_cal_pkg::OFF_W-1:0] cur;
    logic        [W-1:0]                 din;
    logic        [W-1:0]                 dout;
    modport ctl   (output target, output din, input cur, input dout);
    modport store (input target, input din, output cur, output dout);
endinterface
`default_nettype wire

// file: rtl/rtd_buf.sv
/*
 * round-trip delay calibration buffer of 2**depth_log2 entries.
 * assumes one sample is written every cycle; reads lag by half the depth less the current offset.
 */
`timescale 1ns/10ps
`default_nettype none
module rtd_buf #(
    parameter int W                         = 32,
    parameter int round_trip_buf_depth_log2 = lb_cal_pkg::RTD_DEPTH_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    rtd_if.store     io
);
    localparam int N = 2 ** round_trip_buf_depth_log2;
    localparam logic signed [lb_cal_pkg::OFF_W-1:0] LIM = lb_cal_pkg::OFF_W'(N / 2 - 1);
    localparam logic [round_trip_buf_depth_log2-1:0] HALF = round_trip_buf_depth_log2'(N / 2);

    typedef struct packed {
        logic [N-1:0][W-1:0]                  mem;
        logic [round_trip_buf_depth_log2-1:0] wptr;
        logic signed [lb_cal_pkg::OFF_W-1:0]  cur;
        logic [W-1:0]                         dout;
    } buf_t;

    buf_t s;
    buf_t next_s;
    logic signed [lb_cal_pkg::OFF_W-1:0]  goal;
    logic [round_trip_buf_depth_log2-1:0] ridx;

    always_comb begin
        next_s = s;
        goal = io.target;
        if (goal > LIM) begin
            goal = LIM;
        end else if (goal < -LIM) begin
            goal = -LIM;
        end
        // one step a cycle so the read point never jumps
        if (s.cur < goal) begin
            next_s.cur = s.cur + 1'b1;
        end else if (s.cur > goal) begin
            next_s.cur = s.cur - 1'b1;
        end
        ridx = s.wptr - HALF + round_trip_buf_depth_log2'(s.cur);
        next_s.mem[s.wptr] = io.din;
        next_s.wptr = s.wptr + 1'b1;
        next_s.dout = s.mem[ridx];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign io.cur  = s.cur;
    assign io.dout = s.dout;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ptr_bound_a: assert property (s.cur <= LIM && s.cur >= -LIM)
        else $error("read pointer moved past half depth");
    ptr_step_a: assert property (s.cur != $past(s.cur)
        |-> (s.cur - $past(s.cur) == 1 || $past(s.cur) - s.cur == 1))
        else $error("read pointer jumped");
    wrap_a: assert property (s.wptr == round_trip_buf_depth_log2'(N - 1) |=> s.wptr == '0)
        else $error("write pointer does not wrap at depth");
    initial begin
        if (round_trip_buf_depth_log2 < lb_cal_pkg::RTD_DEPTH_MIN
            || round_trip_buf_depth_log2 > lb_cal_pkg::RTD_DEPTH_MAX) begin
            $error("depth setting out of range");
        end
    end
endmodule // rtd_buf
`default_nettype wire

// file: rtl/lb_cal_ctrl.sv
/*
 * loopback and delay calibration control with an axi4-lite register slave.
 * assumes the phy acts on the loopback enables and the calibration blocks
 * report their presence on a pin from another clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module lb_cal_ctrl #(
    parameter bit serial_fwd_lb_opt         = 1'b0,
    parameter bit parallel_fwd_lb_opt       = 1'b0,
    parameter bit parallel_rev_lb_opt       = 1'b0,
    parameter bit single_trip_cal_opt       = 1'b0,
    parameter bit round_trip_cal_opt        = 1'b0,
    parameter bit phy_debug_endpoint        = 1'b0,
    parameter bit autoneg_opt               = 1'b0,
    parameter bit startup_fsm_opt           = 1'b0,
    parameter bit sync_master               = 1'b1,
    parameter bit core_clk_external         = 1'b1,
    parameter int round_trip_buf_depth_log2 = lb_cal_pkg::RTD_DEPTH_DEF,
    parameter int RTD_W                     = 32
) (
    input  wire logic                                aclk,
    input  wire logic                                aresetn,
    input  wire logic [7:0]                          s_axil_awaddr,
    input  wire logic                                s_axil_awvalid,
    output var  logic                                s_axil_awready,
    input  wire logic [31:0]                         s_axil_wdata,
    input  wire logic [3:0]                          s_axil_wstrb,
    input  wire logic                                s_axil_wvalid,
    output var  logic                                s_axil_wready,
    output var  logic [1:0]                          s_axil_bresp,
    output var  logic                                s_axil_bvalid,
    input  wire logic                                s_axil_bready,
    input  wire logic [7:0]                          s_axil_araddr,
    input  wire logic                                s_axil_arvalid,
    output var  logic                                s_axil_arready,
    output var  logic [31:0]                         s_axil_rdata,
    output var  logic [1:0]                          s_axil_rresp,
    output var  logic                                s_axil_rvalid,
    input  wire logic                                s_axil_rready,
    input  wire logic                                cal_blocks_connected,
    input  wire logic [RTD_W-1:0]                    rtd_din,
    output var  logic [RTD_W-1:0]                    rtd_dout,
    output var  logic                                serial_fwd_lb_en,
    output var  logic                                parallel_fwd_lb_en,
    output var  logic [lb_cal_pkg::FWD_W-1:0]        parallel_fwd_lb_sel,
    output var  logic [lb_cal_pkg::REV_W-1:0]        rev_lb_sel,
    output var  logic                                rtd_cal_present,
    output var  logic                                single_trip_cal_active,
    output var  logic                                reconfig_if_present,
    output var  logic                                phy_cal_allowed
);
    localparam bit RTD_ON = round_trip_cal_opt && sync_master;
    localparam bit RECONF_ON = phy_debug_endpoint || autoneg_opt || startup_fsm_opt || single_trip_cal_opt;
    localparam bit ST_ALLOWED = single_trip_cal_opt && core_clk_external;

    typedef struct packed {
        logic                                aw_got;
        logic                                w_got;
        logic [7:0]                          waddr;
        logic [31:0]                         wdata;
        logic [3:0]                          wstrb;
        logic                                awready;
        logic                                wready;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                arready;
        logic                                rvalid;
        logic [1:0]                          rresp;
        logic [31:0]                         rdata;
        logic [31:0]                         loopback_control;
        logic signed [lb_cal_pkg::OFF_W-1:0] rtd_target;
        logic                                conn_s1;
        logic                                conn_s2;
        logic                                ser_en;
        logic                                par_en;
        logic [lb_cal_pkg::FWD_W-1:0]        par_sel;
        logic [lb_cal_pkg::REV_W-1:0]        rev_sel;
        logic                                st_active;
    } ctrl_t;

    ctrl_t s;
    ctrl_t next_s;
    logic signed [lb_cal_pkg::OFF_W-1:0] rtd_cur;
    logic [RTD_W-1:0]                    rtd_q;

    rtd_if #(.W(RTD_W)) rtd ();

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == lb_cal_pkg::OFS_LOOPBACK || a == lb_cal_pkg::OFS_STATUS || a == lb_cal_pkg::OFS_RTD_CTRL;
    endfunction

    always_comb begin
        logic [lb_cal_pkg::FWD_W-1:0] fwd;
        logic [lb_cal_pkg::REV_W-1:0] rev;
        logic [31:0]                  rtdw;
        fwd = '0;
        rev = '0;
        rtdw = '0;
        next_s = s;
        next_s.conn_s1 = cal_blocks_connected;
        next_s.conn_s2 = s.conn_s1;
        if (s_axil_awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.waddr = s_axil_awaddr;
        end
        if (s_axil_wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axil_wdata;
            next_s.wstrb = s_axil_wstrb;
        end
        if (s.bvalid && s_axil_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mapped(s.waddr) ? lb_cal_pkg::RESP_OKAY : lb_cal_pkg::RESP_SLVERR;
            if (s.waddr == lb_cal_pkg::OFS_LOOPBACK) begin
                next_s.loopback_control = merge(s.loopback_control, s.wdata, s.wstrb);
            end
            if (s.waddr == lb_cal_pkg::OFS_RTD_CTRL && s.wstrb[0]) begin
                rtdw = {24'h000000, s.wdata[7:0]};
                next_s.rtd_target = rtdw[lb_cal_pkg::OFF_POS +: lb_cal_pkg::OFF_W];
            end
        end
        if (s.rvalid && s_axil_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axil_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = mapped(s_axil_araddr) ? lb_cal_pkg::RESP_OKAY : lb_cal_pkg::RESP_SLVERR;
            unique case (s_axil_araddr)
                lb_cal_pkg::OFS_LOOPBACK: next_s.rdata = s.loopback_control;
                lb_cal_pkg::OFS_RTD_CTRL: next_s.rdata = 32'({{(32 - lb_cal_pkg::OFF_W){1'b0}}, s.rtd_target});
                lb_cal_pkg::OFS_STATUS: begin
                    next_s.rdata = '0;
                    next_s.rdata[lb_cal_pkg::ST_SER] = s.ser_en;
                    next_s.rdata[lb_cal_pkg::ST_PAR] = s.par_en;
                    next_s.rdata[lb_cal_pkg::ST_REV] = |s.rev_sel;
                    next_s.rdata[lb_cal_pkg::ST_RTD] = RTD_ON;
                    next_s.rdata[lb_cal_pkg::ST_STCAL] = s.st_active;
                    next_s.rdata[lb_cal_pkg::ST_RECONF] = RECONF_ON;
                    next_s.rdata[lb_cal_pkg::ST_DBG] = phy_debug_endpoint;
                    next_s.rdata[lb_cal_pkg::ST_OFF_POS +: lb_cal_pkg::OFF_W] = rtd_cur;
                end
                default: next_s.rdata = '0;
            endcase
        end
        // one write and one read outstanding at most
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
        fwd = next_s.loopback_control[lb_cal_pkg::FWD_POS +: lb_cal_pkg::FWD_W];
        rev = next_s.loopback_control[lb_cal_pkg::REV_POS +: lb_cal_pkg::REV_W];
        next_s.ser_en = serial_fwd_lb_opt && fwd == lb_cal_pkg::FWD_SERIAL;
        next_s.par_en = parallel_fwd_lb_opt && fwd != '0 && !next_s.ser_en;
        next_s.par_sel = next_s.par_en ? fwd : '0;
        next_s.rev_sel = parallel_rev_lb_opt ? rev : '0;
        next_s.st_active = ST_ALLOWED && s.conn_s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rtd.target = s.rtd_target;
    assign rtd.din = rtd_din;

    generate
        if (RTD_ON) begin : g_rtd
            rtd_buf #(
                .W                         (RTD_W),
                .round_trip_buf_depth_log2 (round_trip_buf_depth_log2)
            ) u_rtd_buf (
                .aclk    (aclk),
                .aresetn (aresetn),
                .io      (rtd.store)
            );
        end else begin : g_no_rtd
            assign rtd.cur = '0;
            assign rtd.dout = '0;
        end
    endgenerate

    assign rtd_cur = rtd.cur;
    assign rtd_q = rtd.dout;

    assign s_axil_awready = s.awready;
    assign s_axil_wready = s.wready;
    assign s_axil_bvalid = s.bvalid;
    assign s_axil_bresp = s.bresp;
    assign s_axil_arready = s.arready;
    assign s_axil_rvalid = s.rvalid;
    assign s_axil_rresp = s.rresp;
    assign s_axil_rdata = s.rdata;
    assign rtd_dout = rtd_q;
    assign serial_fwd_lb_en = s.ser_en;
    assign parallel_fwd_lb_en = s.par_en;
    assign parallel_fwd_lb_sel = s.par_sel;
    assign rev_lb_sel = s.rev_sel;
    assign single_trip_cal_active = s.st_active;
    assign rtd_cal_present = RTD_ON;
    assign reconfig_if_present = RECONF_ON;
    assign phy_cal_allowed = phy_debug_endpoint;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence lb_write_s;
        s.aw_got && s.w_got && s.waddr == lb_cal_pkg::OFS_LOOPBACK && s.wstrb[0];
    endsequence

    serial_write_a: assert property (lb_write_s ##0 s.wdata[1:0] == lb_cal_pkg::FWD_SERIAL
        |=> serial_fwd_lb_en == serial_fwd_lb_opt && !parallel_fwd_lb_en)
        else $error("serial loopback not set by field write");
    par_fwd_a: assert property (parallel_fwd_lb_en |-> parallel_fwd_lb_opt && parallel_fwd_lb_sel != '0)
        else $error("parallel forward loopback active without cause");
    par_write_a: assert property (lb_write_s ##0 s.wdata[1:0] == 2'h2
        |=> parallel_fwd_lb_en == parallel_fwd_lb_opt)
        else $error("parallel forward loopback not set by write");
    rev_sel_a: assert property (lb_write_s ##0 s.wdata[7:4] != '0
        |=> rev_lb_sel == (parallel_rev_lb_opt ? $past(s.wdata[7:4]) : '0))
        else $error("reverse loopback select wrong");
    excl_path_a: assert property (!serial_fwd_lb_opt |-> !serial_fwd_lb_en)
        else $error("excluded serial path activated");
    rtd_gate_a: assert property (rtd_cal_present |-> round_trip_cal_opt && sync_master)
        else $error("round-trip calibration present without master");
    reconf_gate_a: assert property (reconfig_if_present == RECONF_ON)
        else $error("reconfiguration presence wrong");
    stcal_conn_a: assert property (single_trip_cal_active |-> ST_ALLOWED && $past(s.conn_s2))
        else $error("single-trip active without blocks");
    dbg_gate_a: assert property (phy_cal_allowed |-> phy_debug_endpoint)
        else $error("phy calibration without debug access");
    bresp_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
        else $error("read data dropped before taken");
    rresp_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=> $stable(s_axil_rresp))
        else $error("read response changed before taken");
    wr_block_a: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
        else $error("write taken while response pending");
    rd_block_a: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read taken while data pending");

    sequence write_commit_s;
        s.aw_got && s.w_got;
    endsequence

    sequence write_answer_s;
        s_axil_bvalid;
    endsequence

    write_resp_a: assert property (write_commit_s |=> write_answer_s)
        else $error("write response missing after address and data");
    unmapped_wr_a: assert property (write_commit_s ##0 !mapped(s.waddr) |=> s_axil_bresp == lb_cal_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    read_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
        else $error("read data missing after address taken");
    excl_par_a: assert property (!parallel_fwd_lb_opt |-> !parallel_fwd_lb_en && parallel_fwd_lb_sel == '0)
        else $error("excluded parallel forward path activated");
    excl_rev_a: assert property (!parallel_rev_lb_opt |-> rev_lb_sel == '0)
        else $error("excluded reverse path activated");
    ser_excl_a: assert property (serial_fwd_lb_en |-> !parallel_fwd_lb_en)
        else $error("serial and parallel forward loopback both on");
    ser_code_a: assert property (serial_fwd_lb_en
        |-> s.loopback_control[lb_cal_pkg::FWD_POS +: lb_cal_pkg::FWD_W] == lb_cal_pkg::FWD_SERIAL)
        else $error("serial loopback on without its code");
    rev_code_a: assert property (rev_lb_sel != '0
        |-> rev_lb_sel == s.loopback_control[lb_cal_pkg::REV_POS +: lb_cal_pkg::REV_W])
        else $error("reverse select differs from field");
    stcal_gate_a: assert property (!ST_ALLOWED |-> !single_trip_cal_active)
        else $error("single-trip active without option or external clock");
endmodule // lb_cal_ctrl
`default_nettype wire

// file: dv/phy_model.sv
/*
 * far-side model: transceiver sample stream and calibration blocks pin.
 * assumes the bench asks for the calibration blocks through attach.
 */
`timescale 1ns/10ps
`default_nettype none
module phy_model (
    input  wire logic        aclk,
    input  wire logic        attach,
    output var  logic        cal_blocks_connected,
    output var  logic [31:0] sample
);
    initial begin
        cal_blocks_connected = 1'b0;
        sample = 32'h00000000;
    end
    always @(posedge aclk) begin
        cal_blocks_connected <= attach;
        sample               <= sample + 32'h00000001;
    end
endmodule // phy_model
`default_nettype wire

// file: dv/tb_top.sv
/*
 * self-checking bench for the loopback and delay calibration control.
 * assumes the phy model supplies one sample per cycle and the cal pin.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int DL2  = 4;
    localparam int HALF = (1 << DL2) / 2;
    localparam bit OPT_ON = 1'b1;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, attach = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, cal_pin, rtd_p, stc, rcf, pcal;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, din, dout;
    wire  [7:0]  on_lb, off_lb;
    wire  [2:0]  off_pres;
    int          error_cnt = 0;
    int          comparisons = 0;

    always #2.5 aclk = ~aclk;

    phy_model phy (.aclk(aclk), .attach(attach), .cal_blocks_connected(cal_pin), .sample(din));

    lb_cal_ctrl #(.serial_fwd_lb_opt(OPT_ON), .parallel_fwd_lb_opt(OPT_ON), .parallel_rev_lb_opt(OPT_ON),
        .single_trip_cal_opt(OPT_ON), .round_trip_cal_opt(OPT_ON), .phy_debug_endpoint(OPT_ON),
        .round_trip_buf_depth_log2(DL2)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .cal_blocks_connected(cal_pin),
        .rtd_din(din), .rtd_dout(dout), .serial_fwd_lb_en(on_lb[0]), .parallel_fwd_lb_en(on_lb[1]),
        .parallel_fwd_lb_sel(on_lb[3:2]), .rev_lb_sel(on_lb[7:4]), .rtd_cal_present(rtd_p),
        .single_trip_cal_active(stc), .reconfig_if_present(rcf), .phy_cal_allowed(pcal));

    // stripped build: loopback options out, round-trip asked for but not master
    lb_cal_ctrl #(.round_trip_cal_opt(1'b1), .sync_master(1'b0)) dut_off (
        .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(), .s_axil_bresp(), .s_axil_bvalid(), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(), .s_axil_rdata(),
        .s_axil_rresp(), .s_axil_rvalid(), .s_axil_rready(rready), .cal_blocks_connected(cal_pin),
        .rtd_din(din), .rtd_dout(), .serial_fwd_lb_en(off_lb[0]), .parallel_fwd_lb_en(off_lb[1]),
        .parallel_fwd_lb_sel(off_lb[3:2]), .rev_lb_sel(off_lb[7:4]), .rtd_cal_present(off_pres[0]),
        .single_trip_cal_active(), .reconfig_if_present(off_pres[1]), .phy_cal_allowed(off_pres[2]));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic stall();
        error_cnt++;
        $display("[FAIL] t=%0t bus wait limit reached got=%h exp=%h", $time, 1'b0, 1'b1);
        give_verdict();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        check({30'h0, got}, {30'h0, exp});
    endtask

    // write address and data offered together, bready held until bvalid
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 64) stall();
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 64) stall();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // expected {rev sel, par sel, par on, serial on}; serial wins on code 01
    function automatic logic [7:0] exp_lb(input logic [31:0] v);
        logic sr;
        logic pr;
        sr = (v[1:0] == lb_cal_pkg::FWD_SERIAL);
        pr = (v[1:0] != 2'h0) && !sr;
        return {v[7:4], (pr ? v[1:0] : 2'h0), pr, sr};
    endfunction

    function automatic int clamp(input int t);
        return (t > HALF - 1) ? HALF - 1 : ((t < 1 - HALF) ? 1 - HALF : t);
    endfunction

    initial begin
        logic [31:0] v, d;
        logic [1:0]  r;
        int          k, lag0;
        int          tgt[5] = '{3, 10, -10, -7, 0};
        void'($urandom(85443));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(lb_cal_pkg::OFS_LOOPBACK, d, r);
        check(d, lb_cal_pkg::RST_LOOPBACK);
        axi_read(lb_cal_pkg::OFS_STATUS, d, r);
        check({28'h0, d[6:3]}, 32'h0000000D);
        check({29'h0, pcal, rcf, rtd_p}, 32'h00000007);
        check({29'h0, off_pres}, 32'h00000000);
        for (k = 0; k < 12; k++) begin
            v = $urandom();
            if (k < 4) v[1:0] = k[1:0];
            axi_write(lb_cal_pkg::OFS_LOOPBACK, v, 4'hF, r);
            check_resp(r, lb_cal_pkg::RESP_OKAY);
            check({24'h0, on_lb}, {24'h0, exp_lb(v)});
            check({24'h0, off_lb}, 32'h00000000);
            axi_read(lb_cal_pkg::OFS_LOOPBACK, d, r);
            check_resp(r, lb_cal_pkg::RESP_OKAY);
            check(d, v);
        end
        axi_write(lb_cal_pkg::OFS_LOOPBACK, ~v, 4'h1, r);
        axi_read(lb_cal_pkg::OFS_LOOPBACK, d, r);
        check(d, {v[31:8], ~v[7:0]});
        axi_write(8'h50, 32'hFFFFFFFF, 4'hF, r);
        check_resp(r, lb_cal_pkg::RESP_SLVERR);
        axi_read(8'h50, d, r);
        check_resp(r, lb_cal_pkg::RESP_SLVERR);
        check({24'h0, on_lb}, {24'h0, exp_lb({v[31:8], ~v[7:0]})});
        $display("test loopback fields done");
        attach <= 1'b1;
        repeat (3) @(posedge aclk);
        check({31'h0, stc}, 32'h00000000);
        repeat (2) @(posedge aclk);
        check({31'h0, stc}, 32'h00000001);
        attach <= 1'b0;
        repeat (5) @(posedge aclk);
        check({31'h0, stc}, 32'h00000000);
        $display("test single trip done");
        lag0 = int'(din - dout);
        check(32'(lag0 >= HALF && lag0 <= HALF + 2), 32'h00000001);
        for (k = 0; k < 5; k++) begin
            axi_write(lb_cal_pkg::OFS_RTD_CTRL, {27'h0, 5'(tgt[k])}, 4'hF, r);
            repeat (16) @(posedge aclk);
            check(din - dout, 32'(lag0 - clamp(tgt[k])));
            axi_read(lb_cal_pkg::OFS_STATUS, d, r);
            check({27'h0, d[12:8]}, {27'h0, 5'(clamp(tgt[k]))});
        end
        $display("test round trip offsets done");
        give_verdict();
    end

    initial begin
        #400000;
        stall();
    end
endmodule // tb_top
`default_nettype wire
